// *** include/cap_pkg.sv ***
/*
  Shared constants for the configuration access port link: port offsets,
  key bytes, register bank size, default register values and the host
  controller's own register map.
  Assumes both ends are compiled after this package.
*/
package cap_pkg;
  // link widths
  localparam int CAP_AW = 16;
  localparam int CAP_DW = 8;
  // configuration register bank
  localparam int CAP_NREG = 48;
  localparam logic [7:0] CAP_LAST_IDX = 8'h2f;
  localparam logic [7:0] CAP_KEY_ENTER = 8'h55;
  localparam logic [7:0] CAP_KEY_EXIT = 8'haa;
  // base address as placed by the strap
  localparam logic [15:0] CAP_BASE_STRAP0 = 16'h03f0;
  localparam logic [15:0] CAP_BASE_STRAP1 = 16'h0370;
  localparam logic [15:0] CAP_DATA_OFS = 16'h0001;
  // base address registers inside the bank
  localparam int CAP_IDX_BASE_LO = 18;
  localparam int CAP_IDX_BASE_HI = 19;
  // identification registers, read only
  localparam int CAP_IDX_DEV_ID = 13;
  localparam int CAP_IDX_DEV_REV = 14;
  localparam logic [7:0] CAP_DEV_ID = 8'h5a; // arbitrary value
  localparam logic [7:0] CAP_DEV_REV = 8'h01; // arbitrary value
  // host controller register map (byte offsets on axi4-lite)
  localparam logic [7:0] CAP_H_ADDR = 8'h00;
  localparam logic [7:0] CAP_H_WDATA = 8'h04;
  localparam logic [7:0] CAP_H_CMD = 8'h08;
  localparam logic [7:0] CAP_H_STATUS = 8'h0c;
  localparam logic [7:0] CAP_H_RDATA = 8'h10;
  localparam int CAP_CMD_WR_BIT = 0;
  localparam int CAP_CMD_RD_BIT = 1;
  localparam int CAP_ST_BUSY_BIT = 0;
  localparam int CAP_ST_DONE_BIT = 1;
  localparam int CAP_ST_NORESP_BIT = 2;
  localparam logic [7:0] CAP_NORESP_DATA = 8'hff;
  localparam int CAP_TIMEOUT = 16;
  localparam logic [1:0] CAP_RESP_OKAY = 2'b00;
  localparam logic [1:0] CAP_RESP_SLVERR = 2'b10;

  // power-up value of each configuration register
  function automatic logic [7:0] cap_default(input int idx);
    case (idx)
      0: cap_default = 8'h28;
      1: cap_default = 8'h9c;
      2: cap_default = 8'h88;
      3: cap_default = 8'h70;
      6: cap_default = 8'hff;
      12: cap_default = 8'h02;
      13: cap_default = CAP_DEV_ID;
      14: cap_default = CAP_DEV_REV;
      17: cap_default = 8'h80;
      18: cap_default = CAP_BASE_STRAP0[7:0];
      19: cap_default = CAP_BASE_STRAP0[15:8];
      23: cap_default = 8'h03;
      default: cap_default = 8'h00;
    endcase
  endfunction

  // true when a select value names an implemented register
  function automatic logic cap_sel_ok(input logic [7:0] sel);
    cap_sel_ok = (sel <= CAP_LAST_IDX);
  endfunction
endpackage

// *** include/cap_link_if.sv ***
/*
  Port-cycle link between the host bus controller and the configuration
  access unit.
  Assumes both ends share one clock; the bench joins them.
*/
interface cap_link_if;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic ack;
  modport host (output addr, output wdata, output wr, output rd, input rdata, input ack);
  modport dev (input addr, input wdata, input wr, input rd, output rdata, output ack);
endinterface

// *** src/cap_dev.sv ***
/*
  Configuration access unit: key port, register select port and data port
  in front of a bank of 48 configuration registers.
  The ports stay locked in the run state, where only the entry key at the
  base address is taken. Once unlocked, the select port picks a register
  and the data port reads or writes it, until the exit key locks them.
  Only rstn_i sets the bank to its power-up values; a hardware reset locks
  the ports, clears the select latch and reloads the two base registers from the strap.
  cfg_bank_o shows every register to the functional units at all times, so
  they keep running while the ports are unlocked.
  Assumes the host raises wr or rd for one cycle with a stable address and
  waits for ack; inputs are synchronous to core_clk_i.
  Assumes hw_reset_i is pulsed once after power-up so the strap is caught.
*/
module cap_dev
  import cap_pkg::*;
(
  // clock and power-up reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // hardware reset and strap
  input wire logic hw_reset_i,
  input wire logic shared_strap_pin_i,
  // link to the host
  cap_link_if.dev link,
  // configuration out to the functional units
  output logic [CAP_NREG*8-1:0] cfg_bank_o,
  output logic cfg_state_o,
  output logic strap_base_select_o,
  output logic [15:0] cfg_base_o
);

  // access state: locked run state or unlocked configuration state
  typedef enum logic [1:0] {
    CAP_RUN = 2'b01,
    CAP_CFG = 2'b10
  } cap_mode_e;

  // whole state of the unit, registered in one place
  typedef struct packed {
    cap_mode_e mode;
    logic [7:0] sel;
    logic [CAP_NREG-1:0][7:0] regs;
    logic strap;
    logic hwrst;
    logic ack;
    logic [7:0] rdata;
  } cap_dev_s;

  cap_dev_s q;
  cap_dev_s d;
  // decoded view of the link address and the select latch
  logic [15:0] base;
  logic hit_key;
  logic hit_data;
  logic [5:0] idx;
  logic ro;

  // power-up value of the whole state
  function automatic cap_dev_s cap_reset_state();
    cap_dev_s s;
    s.mode = CAP_RUN;
    s.sel = 8'h00;
    for (int i = 0; i < CAP_NREG; i++) begin
      s.regs[i] = cap_default(i);
    end
    s.strap = 1'b0;
    s.hwrst = 1'b0;
    s.ack = 1'b0;
    s.rdata = 8'h00;
    return s;
  endfunction

  // true in the configuration state, where select and data ports answer
  function automatic logic cap_unlocked(input cap_mode_e m);
    return (m == CAP_CFG);
  endfunction

  // true when the link address names the given port address
  function automatic logic cap_port_hit(input logic [15:0] a, input logic [15:0] p);
    return (a == p);
  endfunction

  // base from the two base registers: they carry address bits 10:1, while
  // bits 15:11 and bit 0 stay clear, so the ports sit on an even pair
  assign base = {5'h00, q.regs[CAP_IDX_BASE_HI][2:0], q.regs[CAP_IDX_BASE_LO][7:1], 1'b0};
  // key and select share the base address, the data port sits one above
  assign hit_key = cap_port_hit(link.addr, base);
  assign hit_data = cap_port_hit(link.addr, base + CAP_DATA_OFS);
  // only six select bits reach the bank; cap_sel_ok guards the values above
  assign idx = q.sel[5:0];
  // the identification registers keep their values whatever is written
  assign ro = (idx == 6'(CAP_IDX_DEV_ID)) || (idx == 6'(CAP_IDX_DEV_REV));

  // next state: one strobe at a time, ack one cycle after it or never
  always_comb begin
    // defaults: ack is a one-cycle pulse, everything else holds
    d = q;
    d.ack = 1'b0;
    // remember the reset level to find its falling edge
    d.hwrst = hw_reset_i;
    if (hw_reset_i) begin
      // hardware reset locks the ports but leaves the bank alone;
      // strobes in these cycles get no ack and the host times out
      d.mode = CAP_RUN;
      d.sel = 8'h00;
    end else if (q.hwrst) begin
      // falling edge of hardware reset: catch strap, place base
      // the strap only seeds the base registers; software may move them
      // later, and strobes in this one cycle are dropped while base moves
      d.strap = shared_strap_pin_i;
      if (shared_strap_pin_i) begin
        d.regs[CAP_IDX_BASE_LO] = CAP_BASE_STRAP1[7:0];
        d.regs[CAP_IDX_BASE_HI] = CAP_BASE_STRAP1[15:8];
      end else begin
        d.regs[CAP_IDX_BASE_LO] = CAP_BASE_STRAP0[7:0];
        d.regs[CAP_IDX_BASE_HI] = CAP_BASE_STRAP0[15:8];
      end
    end else if (link.wr) begin
      // writes: the key port in both states, the data port only unlocked
      case (q.mode)
        CAP_RUN: begin
          // only the entry key is taken, anything else is dropped;
          // the key port still acks so that a host never hangs on it
          if (hit_key) begin
            d.ack = 1'b1;
            if (link.wdata == CAP_KEY_ENTER) begin
              d.mode = CAP_CFG;
            end
          end
        end
        CAP_CFG: begin
          // unlocked: the key port takes the exit key or a new select
          // value; the entry key written again just loads the latch
          if (hit_key) begin
            d.ack = 1'b1;
            if (link.wdata == CAP_KEY_EXIT) begin
              d.mode = CAP_RUN;
            end else begin
              d.sel = link.wdata;
            end
          end else if (hit_data) begin
            d.ack = 1'b1;
            // writes past the last register or to id registers vanish
            if (cap_sel_ok(q.sel) && !ro) begin
              d.regs[idx] = link.wdata;
            end
          end
        end
        default: begin
          // an illegal state code falls back to the locked state
          d.mode = CAP_RUN;
        end
      endcase
    end else if (link.rd && cap_unlocked(q.mode)) begin
      // reads are only answered while unlocked; in the run state the
      // select port is not readable and the strobe simply gets no ack
      if (hit_key) begin
        // the select latch reads back as written, all eight bits
        d.ack = 1'b1;
        d.rdata = q.sel;
      end else if (hit_data) begin
        // an unimplemented select reads as zero and touches nothing
        d.ack = 1'b1;
        d.rdata = cap_sel_ok(q.sel) ? q.regs[idx] : 8'h00;
      end
    end
  end

  // state register for the whole unit; rstn_i is the only thing that
  // returns the bank to its power-up values
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= cap_reset_state();
    end else begin
      q <= d;
    end
  end

  // link answers
  // ack and read data come straight from flip-flops
  assign link.ack = q.ack;
  assign link.rdata = q.rdata;

  // the bank drives the units whatever the access state
  assign cfg_bank_o = q.regs;
  assign cfg_state_o = cap_unlocked(q.mode);
  // cfg_base_o lets the units see where the ports sit
  assign strap_base_select_o = q.strap;
  assign cfg_base_o = base;

endmodule

// *** src/cap_host.sv ***
/*
  Host end: turns commands from software (axi4-lite registers) into single
  port cycles on the link and reports the answer.
  Assumes an axi4-lite master with one write and one read in flight.
*/
// Design decision made here: the AXI4-Lite slave port.
module cap_host
  import cap_pkg::*;
#(
  parameter int TIMEOUT = CAP_TIMEOUT
)
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // link to the device
  cap_link_if.host link
);

  typedef enum logic [1:0] {
    CAP_H_IDLE = 2'b01,
    CAP_H_WAIT = 2'b10
  } cap_hfsm_e;

  typedef struct packed {
    cap_hfsm_e fsm;
    logic [7:0] timer;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic lwr;
    logic lrd;
    logic op_rd;
    logic [7:0] rdata;
    logic done;
    logic noresp;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
  } cap_host_s;

  cap_host_s q;
  cap_host_s d;
  logic [31:0] status;

  assign status = 32'({q.noresp, q.done, (q.fsm != CAP_H_IDLE)});

  // next state
  always_comb begin
    d = q;
    d.lwr = 1'b0;
    d.lrd = 1'b0;
    // axi channels
    if (s_axi_awvalid_i && !q.aw_hold) begin
      d.aw_hold = 1'b1;
      d.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !q.w_hold) begin
      d.w_hold = 1'b1;
      d.w_data = s_axi_wdata_i;
      d.w_strb = s_axi_wstrb_i;
    end
    if (q.bvalid && s_axi_bready_i) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_hold && q.w_hold && !q.bvalid) begin
      d.aw_hold = 1'b0;
      d.w_hold = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = CAP_RESP_OKAY;
      case (q.aw_addr)
        CAP_H_ADDR: begin
          if (q.w_strb[0]) d.addr[7:0] = q.w_data[7:0];
          if (q.w_strb[1]) d.addr[15:8] = q.w_data[15:8];
        end
        CAP_H_WDATA: begin
          if (q.w_strb[0]) d.wdata = q.w_data[7:0];
        end
        CAP_H_CMD: begin
          // a command while busy is dropped
          if ((q.fsm == CAP_H_IDLE) && q.w_strb[0] &&
              (q.w_data[CAP_CMD_WR_BIT] || q.w_data[CAP_CMD_RD_BIT])) begin
            d.lwr = q.w_data[CAP_CMD_WR_BIT];
            d.lrd = !q.w_data[CAP_CMD_WR_BIT];
            d.op_rd = !q.w_data[CAP_CMD_WR_BIT];
            d.fsm = CAP_H_WAIT;
            d.timer = 8'h00;
            d.done = 1'b0;
            d.noresp = 1'b0;
          end
        end
        CAP_H_STATUS, CAP_H_RDATA: begin
        end
        default: d.bresp = CAP_RESP_SLVERR;
      endcase
    end
    if (q.rvalid && s_axi_rready_i) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.r_resp = CAP_RESP_OKAY;
      case (s_axi_araddr_i)
        CAP_H_ADDR: d.r_data = 32'(q.addr);
        CAP_H_WDATA: d.r_data = 32'(q.wdata);
        CAP_H_CMD: d.r_data = 32'h0000_0000;
        CAP_H_STATUS: d.r_data = status;
        CAP_H_RDATA: d.r_data = 32'(q.rdata);
        default: begin
          d.r_data = 32'h0000_0000;
          d.r_resp = CAP_RESP_SLVERR;
        end
      endcase
    end
    // link cycle: wait for ack or give up
    case (q.fsm)
      CAP_H_IDLE: begin
      end
      CAP_H_WAIT: begin
        if (link.ack) begin
          d.fsm = CAP_H_IDLE;
          d.done = 1'b1;
          // only a read brings data back; a write leaves RDATA as it was
          if (q.op_rd) d.rdata = link.rdata;
        end else if (q.timer == 8'(TIMEOUT - 1)) begin
          d.fsm = CAP_H_IDLE;
          d.done = 1'b1;
          d.noresp = 1'b1;
          d.rdata = CAP_NORESP_DATA;
        end else begin
          d.timer = q.timer + 8'h01;
        end
      end
      default: d.fsm = CAP_H_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
      q.fsm <= CAP_H_IDLE;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign s_axi_awready_o = !q.aw_hold;
  assign s_axi_wready_o = !q.w_hold;
  assign s_axi_bvalid_o = q.bvalid;
  assign s_axi_bresp_o = q.bresp;
  assign s_axi_arready_o = !q.rvalid;
  assign s_axi_rvalid_o = q.rvalid;
  assign s_axi_rdata_o = q.r_data;
  assign s_axi_rresp_o = q.r_resp;
  assign link.addr = q.addr;
  assign link.wdata = q.wdata;
  assign link.wr = q.lwr;
  assign link.rd = q.lrd;

endmodule

// *** test/cap_link_props.sv ***
/*
  Checker for the port-cycle link between host end and device end.
  Assumes both ends run on core_clk_i and the bench wires the link in.
*/
module cap_link_props
  import cap_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // link signals
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic ack
);
  typedef struct packed {
    logic pw;
    logic pr;
    logic [15:0] pa;
    logic [7:0] pd;
    logic cfg;
    logic [15:0] base;
    logic [7:0] sel;
  } cap_shadow_s;
  cap_shadow_s sh_q;
  cap_shadow_s sh_d;

  // shadow of the key state, base and select latch, updated on each ack
  always_comb begin
    sh_d = sh_q;
    sh_d.pw = wr;
    sh_d.pr = rd;
    sh_d.pa = addr;
    sh_d.pd = wdata;
    if (ack && sh_q.pw && !sh_q.cfg && sh_q.pd == CAP_KEY_ENTER) begin
      sh_d.cfg = 1'b1;
      sh_d.base = sh_q.pa;
    end else if (ack && sh_q.pw && sh_q.cfg && sh_q.pa == sh_q.base) begin
      if (sh_q.pd == CAP_KEY_EXIT) begin
        sh_d.cfg = 1'b0;
      end else begin
        sh_d.sel = sh_q.pd;
      end
    end else if (ack && sh_q.pw && sh_q.cfg && sh_q.pa == sh_q.base + 16'h0001) begin
      // base register writes move the ports at once
      if (sh_q.sel == 8'(CAP_IDX_BASE_LO)) begin
        sh_d.base[7:1] = sh_q.pd[7:1];
      end else if (sh_q.sel == 8'(CAP_IDX_BASE_HI)) begin
        sh_d.base[10:8] = sh_q.pd[2:0];
      end
    end
  end

  // shadow register
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sh_q <= '0;
      sh_q.base <= CAP_BASE_STRAP0;
    end else begin
      sh_q <= sh_d;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  ack_single_a: assert property (ack |=> !ack)
    else $error("ack held longer than one cycle");
  ack_cause_a: assert property (ack |-> sh_q.pw || sh_q.pr)
    else $error("ack without a strobe one cycle before");
  strobe_once_a: assert property ((wr || rd) |=> !(wr || rd))
    else $error("strobes closer than the answer allows");
  run_read_a: assert property (rd && !sh_q.cfg |=> !ack)
    else $error("read answered in run state");
  cfg_index_a: assert property (rd && sh_q.cfg && addr == sh_q.base |=> ack && rdata == sh_q.sel)
    else $error("select read wrong or unanswered");
  cfg_data_a: assert property ((wr || rd) && sh_q.cfg && addr == sh_q.base + 16'h0001 |=> ack)
    else $error("data access unanswered in configuration state");
  high_sel_a: assert property (rd && sh_q.cfg && addr == sh_q.base + 16'h0001
    && sh_q.sel > CAP_LAST_IDX |=> ack && rdata == 8'h00)
    else $error("read of unimplemented register not zero");
  run_key_a: assert property (wr && !sh_q.cfg && addr == sh_q.base |=> ack)
    else $error("key write unanswered");
  run_data_a: assert property (wr && !sh_q.cfg && addr == sh_q.base + 16'h0001 |=> !ack)
    else $error("data write answered in run state");
endmodule

// *** test/test_config_access_port_unit.sv ***
/*
  Bench: host end and device end joined by the link, driven over axi4-lite.
  Assumes the package and the link interface are compiled first.
*/
module test_config_access_port_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import cap_pkg::*;
  // stimulus and observed signals
  logic core_clk_i;
  logic rstn_i = 1'b0;
  logic hw_reset_i = 1'b1;
  logic strap = 1'b0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, cfg_state, strap_sel;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rv;
  logic [CAP_NREG*8-1:0] bank;
  logic [15:0] base;
  logic [7:0] q;
  logic nr;
  int failures = 0;
  int checked = 0;
  logic [7:0] idx_t [6] = '{8'h00, 8'h01, 8'h06, 8'h11, 8'h17, 8'h2f};
  logic [7:0] dft_t [6] = '{8'h28, 8'h9c, 8'hff, 8'h80, 8'h03, 8'h00};

  // both ends and the checker on one link
  cap_link_if cap_link_if_i();
  cap_dev cap_dev_i(.core_clk_i(core_clk_i), .rstn_i(rstn_i), .hw_reset_i(hw_reset_i),
    .shared_strap_pin_i(strap), .link(cap_link_if_i.dev), .cfg_bank_o(bank),
    .cfg_state_o(cfg_state), .strap_base_select_o(strap_sel), .cfg_base_o(base));
  cap_host cap_host_i(.core_clk_i(core_clk_i), .rstn_i(rstn_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .link(cap_link_if_i.host));
  cap_link_props cap_link_props_i(.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .addr(cap_link_if_i.addr), .wdata(cap_link_if_i.wdata), .wr(cap_link_if_i.wr),
    .rd(cap_link_if_i.rd), .rdata(cap_link_if_i.rdata), .ack(cap_link_if_i.ack));

  // verdict and end of run
  task stop_test;
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one comparison
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // axi4-lite write, address and data offered together
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge core_clk_i); while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  // axi4-lite read into rv and rsp
  task axi_rd(input logic [7:0] a);
    @(posedge core_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk_i); while (!arready);
    arvalid <= 1'b0;
    do @(posedge core_clk_i); while (!rvalid);
    rv = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  // one port cycle through the host end; result in q and nr
  task port(input logic w, input logic [15:0] a, input logic [7:0] d);
    axi_wr(CAP_H_ADDR, {16'h0, a});
    axi_wr(CAP_H_WDATA, {24'h0, d});
    axi_wr(CAP_H_CMD, w ? 32'h1 : 32'h2);
    chk("cmd resp", 32'(CAP_RESP_OKAY), 32'(rsp));
    rv = '0;
    for (int n = 0; n < 12 && !rv[CAP_ST_DONE_BIT]; n++) axi_rd(CAP_H_STATUS);
    chk("done", 32'h1, 32'(rv[CAP_ST_DONE_BIT]));
    nr = rv[CAP_ST_NORESP_BIT];
    axi_rd(CAP_H_RDATA);
    chk("rdata resp", 32'(CAP_RESP_OKAY), 32'(rsp));
    q = rv[7:0];
  endtask

  // hardware reset pulse with a given strap level
  task hw_pulse(input logic s);
    @(posedge core_clk_i);
    hw_reset_i <= 1'b1;
    strap <= s;
    repeat (3) @(posedge core_clk_i);
    hw_reset_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
  endtask

  // clock
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk_i);
    failures++;
    stop_test();
  end

  // main sequence
  initial begin
    repeat (12) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    hw_pulse(1'b0);
    chk("base", 16'h03f0, base);
    chk("state", 32'h0, cfg_state);
    port(1'b0, 16'h03f0, 8'h00);
    chk("run index noresp", 32'h1, nr);
    port(1'b1, 16'h03f0, 8'h12);
    chk("stray key ack", 32'h0, nr);
    chk("stray key state", 32'h0, cfg_state);
    port(1'b1, 16'h03f1, 8'h77);
    chk("run data wr noresp", 32'h1, nr);
    port(1'b0, 16'h03f1, 8'h00);
    chk("run data rd noresp", 32'h1, nr);
    axi_rd(8'h14);
    chk("unmapped rd resp", CAP_RESP_SLVERR, rsp);
    axi_wr(8'h14, 32'h0);
    chk("unmapped wr resp", CAP_RESP_SLVERR, rsp);
    port(1'b1, 16'h03f0, CAP_KEY_ENTER);
    chk("state", 32'h1, cfg_state);
    for (int i = 0; i < 6; i++) begin
      port(1'b1, 16'h03f0, idx_t[i]);
      port(1'b0, 16'h03f0, 8'h00);
      chk("index", idx_t[i], q);
      port(1'b0, 16'h03f1, 8'h00);
      chk("default", dft_t[i], q);
      port(1'b1, 16'h03f1, dft_t[i] ^ 8'hff);
      port(1'b0, 16'h03f1, 8'h00);
      chk("data", dft_t[i] ^ 8'hff, q);
      chk("bank", dft_t[i] ^ 8'hff, bank[idx_t[i]*8 +: 8]);
    end
    chk("still open", 32'h1, cfg_state);
    port(1'b1, 16'h03f0, 8'(CAP_IDX_DEV_ID));
    port(1'b1, 16'h03f1, 8'h00);
    port(1'b0, 16'h03f1, 8'h00);
    chk("id kept", CAP_DEV_ID, q);
    port(1'b1, 16'h03f0, 8'h30);
    port(1'b1, 16'h03f1, 8'h5a);
    port(1'b0, 16'h03f1, 8'h00);
    chk("high select", 32'h0, {nr, q});
    port(1'b1, 16'h03f0, CAP_KEY_EXIT);
    chk("state", 32'h0, cfg_state);
    port(1'b0, 16'h03f1, 8'h00);
    chk("exit noresp", 32'h1, nr);
    hw_pulse(1'b1);
    chk("base", 16'h0370, base);
    chk("strap", 32'h1, strap_sel);
    chk("kept", 8'hd7, bank[7:0]);
    port(1'b1, 16'h0370, CAP_KEY_ENTER);
    port(1'b1, 16'h0370, 8'h12);
    port(1'b1, 16'h0371, 8'h00);
    chk("moved base", 16'h0300, base);
    port(1'b0, 16'h0300, 8'h00);
    chk("moved index", 8'h12, q);
    stop_test();
  end
endmodule
